// ===== logic/arl_pkg.sv
// Shared constants and types for the alarm relay logic.
// Assumes a 100 MHz ref_clk and a 32-bit plain register port.
package arl_pkg;

    // Sizes
    localparam int ARL_NUM_ALARMS  = 8;
    localparam int ARL_NUM_RELAYS  = 8;
    localparam int ARL_ADDR_W      = 8;
    localparam int ARL_DATA_W      = 32;
    localparam int ARL_COUNT_W     = 4;

    // Register byte offsets
    localparam logic [7:0] ARL_OFF_COUNT    = 8'h00;
    localparam logic [7:0] ARL_OFF_LATCH    = 8'h04;
    localparam logic [7:0] ARL_OFF_EARLY    = 8'h08;
    localparam logic [7:0] ARL_OFF_TOUT     = 8'h0c;
    localparam logic [7:0] ARL_OFF_POL      = 8'h10;
    localparam logic [7:0] ARL_OFF_BOOL     = 8'h14;
    localparam logic [7:0] ARL_OFF_STATE    = 8'h18;
    localparam logic [7:0] ARL_OFF_IRQ_STAT = 8'h1c;
    localparam logic [7:0] ARL_OFF_IRQ_EN   = 8'h20;
    localparam logic [7:0] ARL_OFF_IRQ_CLR  = 8'h24;
    localparam logic [7:0] ARL_OFF_ALLOC    = 8'h40;

    // Field positions
    localparam int ARL_STATE_RELAY_LSB = 8;
    localparam int ARL_IRQ_ACK_BIT     = 8;

    // Reset values
    localparam logic [3:0] ARL_COUNT_RST = 4'h2;
    localparam logic [7:0] ARL_CFG_RST   = 8'h00;
    localparam logic [7:0] ARL_ALLOC_RST = 8'h00;

    // Annunciator flash timing
    localparam int ARL_CLK_PERIOD_NS   = 10;
    localparam int ARL_FLASH_PERIOD_MS = 1000;
    localparam int ARL_FLASH_CYCLES    = ARL_FLASH_PERIOD_MS * 1000000 / ARL_CLK_PERIOD_NS;

    // Per-alarm latch state
    typedef enum logic [1:0] {
        ARL_IDLE        = 2'b00,
        ARL_ALARM_UNACK = 2'b01,
        ARL_CLEAR_UNACK = 2'b10,
        ARL_ACKED       = 2'b11
    } arl_state_t;

    // Annunciator pattern
    typedef enum logic [1:0] {
        ARL_ANN_OFF   = 2'b00,
        ARL_ANN_FAST  = 2'b01,
        ARL_ANN_SLOW  = 2'b10,
        ARL_ANN_SOLID = 2'b11
    } arl_ann_t;

endpackage : arl_pkg

// ===== logic/arl_alarm_latch.sv
// One alarm's latching and acknowledge state machine.
// Assumes in_alarm already carries hysteresis and trip/reset delays.
`timescale 1ns/1ps
module arl_alarm_latch
    import arl_pkg::*;
(
    input  wire logic     ref_clk,
    input  wire logic     rst_n,
    input  wire logic     in_alarm,
    input  wire logic     latching,
    input  wire logic     early_ack,
    input  wire logic     ack_pulse,
    output logic          active,
    output arl_ann_t      ann_mode
);

    arl_state_t state;
    arl_state_t next_state;

    // Latch state transitions
    always_comb begin
        next_state = state;
        case (state)
            ARL_IDLE:        if (in_alarm) next_state = ARL_ALARM_UNACK;
            ARL_ALARM_UNACK: begin
                if (ack_pulse && early_ack && in_alarm) next_state = ARL_ACKED;
                else if (!in_alarm) next_state = ARL_CLEAR_UNACK;
            end
            ARL_CLEAR_UNACK: begin
                if (in_alarm) next_state = ARL_ALARM_UNACK;
                else if (ack_pulse) next_state = ARL_IDLE;
            end
            ARL_ACKED:       if (!in_alarm) next_state = ARL_IDLE;
            default:         next_state = ARL_IDLE;
        endcase
        if (!latching) next_state = ARL_IDLE;
    end

    // State register, cleared at power-up
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) state <= ARL_IDLE;
        else        state <= next_state;
    end

    // Relay demand: follows input when not latching
    assign active = latching ? (state != ARL_IDLE) : in_alarm;

    // Annunciator pattern per state
    assign ann_mode = !latching                   ? (in_alarm ? ARL_ANN_SOLID : ARL_ANN_OFF) :
                      (state == ARL_ALARM_UNACK)  ? ARL_ANN_FAST :
                      (state == ARL_CLEAR_UNACK)  ? ARL_ANN_SLOW :
                      (state == ARL_ACKED)        ? ARL_ANN_SOLID : ARL_ANN_OFF;

    chk_nonlatch_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!latching && $fell(in_alarm) && $past(!latching)) |-> !active)
        else $error("non-latching alarm did not release");

    chk_latch_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (latching && (state == ARL_CLEAR_UNACK) && !ack_pulse && !in_alarm)
        |=> (active || !latching))
        else $error("latched alarm released without acknowledge");

    chk_enter_flash: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (latching && (state == ARL_IDLE) && in_alarm) |=> (ann_mode == ARL_ANN_FAST || !latching))
        else $error("annunciator not flashing on alarm entry");

    chk_long_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (latching && (state == ARL_ALARM_UNACK) && !in_alarm && !ack_pulse)
        |=> (state == ARL_CLEAR_UNACK) || !latching)
        else $error("unacknowledged clear did not switch pattern");

    chk_ack_solid: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (latching && state == ARL_ALARM_UNACK && in_alarm && early_ack && ack_pulse)
        |=> (state == ARL_ACKED) ##0 (ann_mode == ARL_ANN_SOLID || !latching))
        else $error("acknowledge did not light annunciator solid");

    chk_acked_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (latching && (state == ARL_ACKED) && !in_alarm) |=> (state == ARL_IDLE))
        else $error("acknowledged alarm did not release");

endmodule : arl_alarm_latch

// ===== logic/arl_relay_logic.sv
// Alarm-to-relay logic: per-alarm latching, relay combining, polarity,
// annunciator flashing, operator acknowledge and interrupt.
// Assumes alarm flags are synchronous to ref_clk; acknowledge inputs pass a two-flop synchroniser;
// software reaches the registers over a plain strobe port.
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
module arl_relay_logic
    import arl_pkg::*;
#(
    parameter int NA           = ARL_NUM_ALARMS,
    parameter int NR           = ARL_NUM_RELAYS,
    parameter int FLASH_CYCLES = ARL_FLASH_CYCLES
)
(
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic [ARL_ADDR_W-1:0] addr,
    input  wire logic [ARL_DATA_W-1:0] wr_data,
    input  wire logic                  wr_strobe,
    input  wire logic                  rd_strobe,
    output logic      [ARL_DATA_W-1:0] rd_data,
    input  wire logic [NA-1:0]         alarm_cond,
    input  wire logic                  input_timeout,
    input  wire logic                  ack_button,
    input  wire logic                  ack_remote,
    output logic      [NR-1:0]         relay_drive,
    output logic      [NA-1:0]         annunciator,
    output logic                       irq
);

    localparam int FLASH_W = $clog2(FLASH_CYCLES);
    localparam int IRQ_W   = NA + 1;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and status storage

    logic [ARL_COUNT_W-1:0] active_alarm_count;
    logic [NA-1:0]          latching_setting;
    logic [NA-1:0]          early_acknowledge_enable;
    logic [NA-1:0]          timeout_enable;
    logic [NR-1:0]          relay_polarity;
    logic [NR-1:0]          relay_and_mode;
    logic [NA-1:0]          relay_alloc [NR];
    logic [IRQ_W-1:0]       irq_status;
    logic [IRQ_W-1:0]       irq_enable;
    logic [NR-1:0]          relay_state;

    ////////////////////////////////////////////////////////////////////////////
    // Register address decode

    wire        hit_count   = (addr == ARL_OFF_COUNT);
    wire        hit_latch   = (addr == ARL_OFF_LATCH);
    wire        hit_early   = (addr == ARL_OFF_EARLY);
    wire        hit_tout    = (addr == ARL_OFF_TOUT);
    wire        hit_pol     = (addr == ARL_OFF_POL);
    wire        hit_bool    = (addr == ARL_OFF_BOOL);
    wire        hit_state   = (addr == ARL_OFF_STATE);
    wire        hit_irq_st  = (addr == ARL_OFF_IRQ_STAT);
    wire        hit_irq_en  = (addr == ARL_OFF_IRQ_EN);
    wire        hit_irq_clr = (addr == ARL_OFF_IRQ_CLR);
    wire [2:0]  alloc_idx   = addr[4:2];
    wire        hit_alloc   = (addr[7:5] == ARL_OFF_ALLOC[7:5]) && (addr[1:0] == 2'h0)
                              && (32'(alloc_idx) < NR);

    wire        wr_count    = wr_strobe && hit_count;
    wire        wr_latch    = wr_strobe && hit_latch;
    wire        wr_early    = wr_strobe && hit_early;
    wire        wr_tout     = wr_strobe && hit_tout;
    wire        wr_pol      = wr_strobe && hit_pol;
    wire        wr_bool     = wr_strobe && hit_bool;
    wire        wr_irq_en   = wr_strobe && hit_irq_en;
    wire        wr_irq_clr  = wr_strobe && hit_irq_clr;
    wire        wr_alloc    = wr_strobe && hit_alloc;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    // Alarm count and per-alarm settings
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_alarm_count       <= ARL_COUNT_RST;
            latching_setting         <= NA'(ARL_CFG_RST);
            early_acknowledge_enable <= NA'(ARL_CFG_RST);
            timeout_enable           <= NA'(ARL_CFG_RST);
        end else begin
            if (wr_count) active_alarm_count <= wr_data[ARL_COUNT_W-1:0];
            if (wr_latch) latching_setting <= wr_data[NA-1:0];
            if (wr_early) early_acknowledge_enable <= wr_data[NA-1:0];
            if (wr_tout)  timeout_enable <= wr_data[NA-1:0];
        end
    end

    // Per-relay polarity and combining mode
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            relay_polarity <= NR'(ARL_CFG_RST);
            relay_and_mode <= NR'(ARL_CFG_RST);
        end else begin
            if (wr_pol)  relay_polarity <= wr_data[NR-1:0];
            if (wr_bool) relay_and_mode <= wr_data[NR-1:0];
        end
    end

    // Alarm allocation, one mask per relay
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int r = 0; r < NR; r++) relay_alloc[r] <= NA'(ARL_ALLOC_RST);
        end else if (wr_alloc) begin
            relay_alloc[alloc_idx] <= wr_data[NA-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Acknowledge synchroniser and edge detector

    logic ack_meta;
    logic ack_sync;
    logic ack_prev;
    wire  ack_raw   = ack_button | ack_remote;
    wire  ack_pulse = ack_sync & ~ack_prev;

    // Two flops then an edge register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
            ack_prev <= 1'b0;
        end else begin
            ack_meta <= ack_raw;
            ack_sync <= ack_meta;
            ack_prev <= ack_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-alarm gating and latching

    logic [NA-1:0] count_mask;
    logic [NA-1:0] alarm_in;
    logic [NA-1:0] alarm_raw_act;
    logic [NA-1:0] alarm_act;
    arl_ann_t      ann_mode [NA];

    // Alarm flags come from channel one, already delayed and with hysteresis
    generate
        for (genvar i = 0; i < NA; i++) begin : g_alarm
            assign count_mask[i] = (32'(active_alarm_count) > i);
            assign alarm_in[i]   = count_mask[i] &&
                                   (alarm_cond[i] || (timeout_enable[i] && input_timeout));
            assign alarm_act[i]  = alarm_raw_act[i] & count_mask[i];

            arl_alarm_latch u_latch (
                .ref_clk   (ref_clk),
                .rst_n     (rst_n),
                .in_alarm  (alarm_in[i]),
                .latching  (latching_setting[i]),
                .early_ack (early_acknowledge_enable[i]),
                .ack_pulse (ack_pulse),
                .active    (alarm_raw_act[i]),
                .ann_mode  (ann_mode[i])
            );

            chk_timeout_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
                (timeout_enable[i] && input_timeout && count_mask[i] && !wr_strobe)
                ##1 input_timeout |-> alarm_act[i])
                else $error("timeout did not raise alarm");

            // Alarms beyond the configured count stay dark
            chk_count_dark: assert property (@(posedge ref_clk) disable iff (!rst_n)
                !count_mask[i] |=> !annunciator[i])
                else $error("alarm beyond count lit its annunciator");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Relay combining and polarity

    logic [NR-1:0] relay_on;
    logic [NR-1:0] next_relay_drive;

    generate
        for (genvar r = 0; r < NR; r++) begin : g_relay
            wire [NA-1:0] sel = relay_alloc[r] & count_mask;
            wire          any = |(sel & alarm_act);
            wire          all = (sel != '0) && ((sel & ~alarm_act) == '0);
            assign relay_on[r]         = relay_and_mode[r] ? all : any;
            assign next_relay_drive[r] = relay_on[r] ^ relay_polarity[r];

            chk_relay_or: assert property (@(posedge ref_clk) disable iff (!rst_n)
                (!relay_and_mode[r] && !relay_polarity[r] && |(sel & alarm_act))
                |=> relay_drive[r])
                else $error("OR relay not active with an alarm present");

            chk_relay_and: assert property (@(posedge ref_clk) disable iff (!rst_n)
                (relay_and_mode[r] && !relay_polarity[r] && ((sel & ~alarm_act) != '0))
                |=> !relay_drive[r])
                else $error("AND relay active with an alarm missing");

            chk_relay_nc: assert property (@(posedge ref_clk) disable iff (!rst_n)
                (relay_polarity[r] && !relay_on[r]) |=> relay_drive[r])
                else $error("normally closed relay not energised at rest");

            // Normally open contact stays open outside alarm
            chk_relay_open: assert property (@(posedge ref_clk) disable iff (!rst_n)
                (!relay_polarity[r] && !relay_on[r]) |=> !relay_drive[r])
                else $error("normally open relay energised at rest");
        end
    endgenerate

    // Relay outputs and state, cleared to non-alarm
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            relay_drive <= '0;
            relay_state <= '0;
        end else begin
            relay_drive <= next_relay_drive;
            relay_state <= relay_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Annunciator flashing

    logic [FLASH_W-1:0] flash_cnt;
    logic [NA-1:0]      next_ann;
    wire                flash_wrap = (flash_cnt == FLASH_W'(FLASH_CYCLES - 1));
    wire                fast_on    = (flash_cnt < FLASH_W'(FLASH_CYCLES / 2));
    wire                slow_on    = (flash_cnt < FLASH_W'(FLASH_CYCLES / 4));

    // Free-running flash period counter
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)          flash_cnt <= '0;
        else if (flash_wrap) flash_cnt <= '0;
        else                 flash_cnt <= flash_cnt + FLASH_W'(1);
    end

    // Pattern to lamp level
    always_comb begin
        for (int i = 0; i < NA; i++) begin
            case (ann_mode[i])
                ARL_ANN_FAST:  next_ann[i] = fast_on;
                ARL_ANN_SLOW:  next_ann[i] = slow_on;
                ARL_ANN_SOLID: next_ann[i] = 1'b1;
                default:       next_ann[i] = 1'b0;
            endcase
            next_ann[i] = next_ann[i] & count_mask[i];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) annunciator <= '0;
        else        annunciator <= next_ann;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, enable and clear

    logic [NA-1:0]    alarm_prev;
    wire  [IRQ_W-1:0] irq_event = {ack_pulse, alarm_act & ~alarm_prev};
    wire  [IRQ_W-1:0] irq_clr   = wr_irq_clr ? wr_data[IRQ_W-1:0] : '0;

    // Sticky bits; a new event beats a clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_prev <= '0;
            irq_status <= '0;
            irq_enable <= '0;
            irq        <= 1'b0;
        end else begin
            alarm_prev <= alarm_act;
            irq_status <= (irq_status & ~irq_clr) | irq_event;
            if (wr_irq_en) irq_enable <= wr_data[IRQ_W-1:0];
            irq        <= |(irq_status & irq_enable);
        end
    end

    chk_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (|(irq_status & irq_enable)) |=> irq)
        else $error("interrupt not raised for enabled status");

    chk_ack_single: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ack_pulse |=> !ack_pulse)
        else $error("acknowledge pulse longer than one cycle");

    // Status bit set by an event stands after that edge, even beside a clear
    chk_irq_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (irq_event != '0) |=> ((irq_status & $past(irq_event)) == $past(irq_event)))
        else $error("interrupt event lost against a clear");

    ////////////////////////////////////////////////////////////////////////////
    // Read data path

    logic [ARL_DATA_W-1:0] read_mux;

    // Unmapped and write-only addresses read zero
    always_comb begin
        read_mux = '0;
        if (hit_count)       read_mux[ARL_COUNT_W-1:0] = active_alarm_count;
        else if (hit_latch)  read_mux[NA-1:0] = latching_setting;
        else if (hit_early)  read_mux[NA-1:0] = early_acknowledge_enable;
        else if (hit_tout)   read_mux[NA-1:0] = timeout_enable;
        else if (hit_pol)    read_mux[NR-1:0] = relay_polarity;
        else if (hit_bool)   read_mux[NR-1:0] = relay_and_mode;
        else if (hit_state) begin
            read_mux[NA-1:0] = alarm_act;
            read_mux[ARL_STATE_RELAY_LSB +: NR] = relay_state;
        end
        else if (hit_irq_st) read_mux[IRQ_W-1:0] = irq_status;
        else if (hit_irq_en) read_mux[IRQ_W-1:0] = irq_enable;
        else if (hit_alloc)  read_mux[NA-1:0] = relay_alloc[alloc_idx];
    end

    // Data valid only in the cycle after the read strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)         rd_data <= '0;
        else if (rd_strobe) rd_data <= read_mux;
        else                rd_data <= '0;
    end

    // Read data stands one cycle only
    chk_rd_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !rd_strobe |=> (rd_data == '0))
        else $error("read data not zero outside a read");

endmodule : arl_relay_logic

// ===== bench/arl_operator_model.sv
// Operator side model: front acknowledge pushbutton and remote input.
// Assumes ack_req is a one-cycle request from the bench, on ref_clk.
`timescale 1ns/1ps
module arl_operator_model (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic ack_req,
    input  wire logic use_remote,
    output logic      ack_button,
    output logic      ack_remote
);
    logic [1:0] hold;

    // Press lasts three cycles, then the line drops back low
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            hold <= 2'h0;
        else if (ack_req)
            hold <= 2'h3;
        else if (hold != 2'h0)
            hold <= hold - 2'h1;
    end

    // Either the pushbutton or the remote input carries the press
    assign ack_button = (hold != 2'h0) && !use_remote;
    assign ack_remote = (hold != 2'h0) && use_remote;
endmodule : arl_operator_model

// ===== bench/test_arl_relay_logic.sv
// Bench for the alarm relay logic: register tasks and scenario calls.
// Assumes the operator model drives both acknowledge inputs.
`timescale 1ns/1ps
module test_arl_relay_logic import arl_pkg::*;;
    logic ref_clk = 1'b0, rst_n = 1'b0, wr_strobe = 1'b0, rd_strobe = 1'b0;
    logic input_timeout = 1'b0, ack_req = 1'b0, use_remote = 1'b0;
    logic [7:0] addr = 8'h00, alarm_cond = 8'h00, relay_drive, annunciator;
    logic [31:0] wr_data = 32'h0, rd_data, got, ones;
    logic irq, ack_button, ack_remote;
    int failures = 0, total_checks = 0, cycles = 0;

    // Clock and hang guard
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            test_done();
        end
    end

    arl_relay_logic #(.FLASH_CYCLES(16)) i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
        .alarm_cond(alarm_cond), .input_timeout(input_timeout),
        .ack_button(ack_button), .ack_remote(ack_remote),
        .relay_drive(relay_drive), .annunciator(annunciator), .irq(irq));
    arl_operator_model i_op (
        .ref_clk(ref_clk), .rst_n(rst_n), .ack_req(ack_req),
        .use_remote(use_remote), .ack_button(ack_button), .ack_remote(ack_remote));

    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_strobe <= 1'b1;
        @(posedge ref_clk);
        wr_strobe <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge ref_clk);
        rd_strobe <= 1'b0;
        #1;
        got = rd_data;
    endtask : rd
    task automatic ack(input logic r);
        @(posedge ref_clk);
        use_remote <= r;
        ack_req <= 1'b1;
        @(posedge ref_clk);
        ack_req <= 1'b0;
        tick(10);
    endtask : ack
    // Lamp on-cycles over one flash period
    task automatic count_on();
        ones = 32'h0;
        repeat (16) begin
            @(posedge ref_clk);
            #1;
            ones = ones + 32'(annunciator[0]);
        end
    endtask : count_on
    task automatic cmp_word(input string name, input logic [31:0] exp, input logic [31:0] seen);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : cmp_word
    task automatic cmp_bit(input string name, input logic exp, input logic seen);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %b seen %b", name, exp, seen);
        end
    endtask : cmp_bit
    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////
    // Scenario sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(ARL_OFF_COUNT);
        cmp_word("count", 32'h2, got);
        cmp_word("relays", 32'h0, 32'(relay_drive));
        rd(8'h3c);
        cmp_word("unmapped", 32'h0, got);
        wr(ARL_OFF_ALLOC, 32'h1);
        wr(ARL_OFF_ALLOC + 8'h04, 32'h3);
        wr(ARL_OFF_BOOL, 32'h2);
        wr(ARL_OFF_IRQ_EN, 32'h1);
        @(posedge ref_clk) alarm_cond <= 8'h01;
        tick(4);
        cmp_bit("relay0", 1'b1, relay_drive[0]);
        cmp_bit("relay1", 1'b0, relay_drive[1]);
        cmp_bit("irq", 1'b1, irq);
        @(posedge ref_clk) alarm_cond <= 8'h03;
        tick(4);
        cmp_bit("relay1", 1'b1, relay_drive[1]);
        @(posedge ref_clk) alarm_cond <= 8'h00;
        tick(4);
        cmp_bit("relay0", 1'b0, relay_drive[0]);
        rd(ARL_OFF_IRQ_STAT);
        cmp_word("irq status", 32'h3, got);
        wr(ARL_OFF_IRQ_CLR, 32'h1ff);
        tick(3);
        cmp_bit("irq", 1'b0, irq);
        // Latching, refused ack in alarm, then ack out of alarm
        wr(ARL_OFF_LATCH, 32'h1);
        @(posedge ref_clk) alarm_cond <= 8'h01;
        tick(4);
        count_on();
        cmp_word("fast lamp", 32'd8, ones);
        ack(1'b1);
        @(posedge ref_clk) alarm_cond <= 8'h00;
        tick(4);
        cmp_bit("relay0", 1'b1, relay_drive[0]);
        count_on();
        cmp_word("slow lamp", 32'd4, ones);
        ack(1'b0);
        cmp_bit("relay0", 1'b0, relay_drive[0]);
        // Early acknowledge while in alarm
        wr(ARL_OFF_EARLY, 32'h1);
        @(posedge ref_clk) alarm_cond <= 8'h01;
        tick(4);
        ack(1'b1);
        count_on();
        cmp_word("solid lamp", 32'd16, ones);
        cmp_bit("relay0", 1'b1, relay_drive[0]);
        @(posedge ref_clk) alarm_cond <= 8'h00;
        tick(4);
        cmp_bit("relay0", 1'b0, relay_drive[0]);
        // Polarity, timeout, alarm count
        wr(ARL_OFF_POL, 32'h1);
        tick(3);
        cmp_bit("relay0", 1'b1, relay_drive[0]);
        wr(ARL_OFF_POL, 32'h0);
        wr(ARL_OFF_LATCH, 32'h0);
        wr(ARL_OFF_TOUT, 32'h1);
        @(posedge ref_clk) input_timeout <= 1'b1;
        tick(4);
        cmp_bit("relay0", 1'b1, relay_drive[0]);
        @(posedge ref_clk) input_timeout <= 1'b0;
        wr(ARL_OFF_COUNT, 32'h0);
        @(posedge ref_clk) alarm_cond <= 8'h01;
        tick(4);
        cmp_bit("relay0", 1'b0, relay_drive[0]);
        rd(ARL_OFF_STATE);
        cmp_word("state", 32'h0, got);
        test_done();
    end
endmodule : test_arl_relay_logic
